// File: logic/macrocell_map.svh
`ifndef MACROCELL_MAP_SVH
`define MACROCELL_MAP_SVH

// *****************************
// array sizes
// *****************************
`define N_MACROCELLS     10
`define N_DED_INPUTS     10
`define N_LOGIC_TERMS    4
`define N_TERMS          8
`define N_LITERALS       30

// *****************************
// product term slots within one macrocell
// *****************************
`define TERM_LOGIC0      0
`define TERM_RESET       4
`define TERM_PRESET      5
`define TERM_CLOCK       6
`define TERM_OE          7

// *****************************
// user signature
// *****************************
`define SIG_BITS         64
`define SIG_FUSE_FIRST   3210
`define SIG_FUSE_LAST    3273

// *****************************
// reset values
// *****************************
`define RST_Q            10'h000
`define RST_PIN_OUT      10'h3ff
`define RST_PIN_OE_N     10'h3ff
`define RST_CLK_PREV     10'h3ff
`define RST_SYNC_LOW     10'h000
`define RST_PRELOAD_N    1'h1
`define RST_OUT_EN_N     1'h1

`endif

// File: logic/pld_pkg.sv
package pld_pkg;
`include "macrocell_map.svh"

    typedef logic [`N_MACROCELLS-1:0] mc_vec_t;

    typedef struct packed {
        logic [`N_LITERALS-1:0] true_sel;
        logic [`N_LITERALS-1:0] comp_sel;
    } pterm_t;

    typedef struct packed {
        logic                   polarity;
        pterm_t [`N_TERMS-1:0]  term;
    } macrocell_cfg_t;

    typedef macrocell_cfg_t [`N_MACROCELLS-1:0] fuse_map_t;

    typedef struct packed {
        logic [`N_DED_INPUTS-1:0] in_s1;
        logic [`N_DED_INPUTS-1:0] in_s2;
        mc_vec_t                  io_s1;
        mc_vec_t                  io_s2;
        logic                     pre_s1;
        logic                     pre_s2;
        logic                     oe_s1;
        logic                     oe_s2;
        mc_vec_t                  q;
        mc_vec_t                  clk_prev;
        mc_vec_t                  pin_out;
        mc_vec_t                  pin_oe_n;
    } state_t;

endpackage

// File: logic/async_register_macrocells.sv
`timescale 1ns/1ps
`include "macrocell_map.svh"
// Function
// - ten macrocells, each one flip-flop with own reset, preset, clock terms.
// - data input is OR of four logic terms through per-cell polarity XNOR.
// - a logic term active gives data low for polarity 0, high for 1.
// - polarity only affects clocked and bypass data; reset, preset, preload ignore it.
// - each flip-flop captures on the rising edge of its own clock term.
// - up to ten clocks built from pins and flip-flop feedback.
// - pin driven only with its enable term active and shared enable pin low.
// - reset and preset terms are levels holding the flip-flop while active.
// - output buffer inverts; reset gives pin high, preset gives pin low.
// - reset/preset 00 registered, 10 clear, 01 set, 11 bypass.
// - with both terms active, data input goes straight to inverting buffer.
// - preload pin low loads each flip-flop whose output is not enabled from its io pin.
// - during preload, io pin low sets, io pin high clears the flip-flop.
// - a flip-flop whose output is enabled keeps its state during preload.
// - ten dedicated inputs and ten io pins, each with its own array path.
// - all registers take a defined state at power-up reset.
// - 64 user signature bits in eight bytes, fuse addresses 3210 to 3273.
module async_register_macrocells #(
    parameter logic [63:0] SIGNATURE = 64'h5a5a_0000_0000_a5a5  // arbitrary value
) (
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    input  wire pld_pkg::fuse_map_t  fuse_map,
    input  wire logic [9:0]          ded_in,
    input  wire pld_pkg::mc_vec_t    io_in,
    output pld_pkg::mc_vec_t         io_out,
    output pld_pkg::mc_vec_t         io_oe_n,
    input  wire logic                preload_n,
    input  wire logic                out_en_n,
    output logic [63:0]              user_signature
);
    import pld_pkg::*;

    // *****************************
    // product term evaluation
    // *****************************
    function automatic logic term_active(input pterm_t t, input logic [`N_LITERALS-1:0] lits);
        term_active = ((t.true_sel & ~lits) == '0) && ((t.comp_sel & lits) == '0);
    endfunction

    state_t                  s_r;
    state_t                  s_nxt;
    logic [`N_LITERALS-1:0]  lits;
    mc_vec_t                 any_v;
    mc_vec_t                 pol_v;
    mc_vec_t                 d_v;
    mc_vec_t                 rst_v;
    mc_vec_t                 pre_v;
    mc_vec_t                 ck_v;
    mc_vec_t                 edge_v;
    mc_vec_t                 oet_v;
    mc_vec_t                 en_v;

    // *****************************
    // combinational next state
    // *****************************
    always_comb begin
        lits   = {s_r.q, s_r.io_s2, s_r.in_s2};
        any_v  = '0;
        pol_v  = '0;
        d_v    = '0;
        rst_v  = '0;
        pre_v  = '0;
        ck_v   = '0;
        oet_v  = '0;
        s_nxt  = s_r;
        s_nxt.in_s1  = ded_in;
        s_nxt.in_s2  = s_r.in_s1;
        s_nxt.io_s1  = io_in;
        s_nxt.io_s2  = s_r.io_s1;
        s_nxt.pre_s1 = preload_n;
        s_nxt.pre_s2 = s_r.pre_s1;
        s_nxt.oe_s1  = out_en_n;
        s_nxt.oe_s2  = s_r.oe_s1;
        for (int i = 0; i < `N_MACROCELLS; i++) begin
            for (int k = 0; k < `N_LOGIC_TERMS; k++) begin
                any_v[i] = any_v[i] | term_active(fuse_map[i].term[`TERM_LOGIC0 + k], lits);
            end
            pol_v[i] = fuse_map[i].polarity;
            d_v[i]   = ~(any_v[i] ^ pol_v[i]);
            rst_v[i] = term_active(fuse_map[i].term[`TERM_RESET], lits);
            pre_v[i] = term_active(fuse_map[i].term[`TERM_PRESET], lits);
            ck_v[i]  = term_active(fuse_map[i].term[`TERM_CLOCK], lits);
            oet_v[i] = term_active(fuse_map[i].term[`TERM_OE], lits);
        end
        edge_v = ck_v & ~s_r.clk_prev;
        en_v   = oet_v & {`N_MACROCELLS{~s_r.oe_s2}};
        for (int i = 0; i < `N_MACROCELLS; i++) begin
            // preload overrides reset, preset and clock, not the bypass pin; polarity never enters the preload load
            if (!s_r.pre_s2) begin
                if (!en_v[i]) begin
                    s_nxt.q[i] = ~s_r.io_s2[i];
                end
            end else if (rst_v[i] && !pre_v[i]) begin
                s_nxt.q[i] = 1'b0;
            end else if (pre_v[i] && !rst_v[i]) begin
                s_nxt.q[i] = 1'b1;
            end else if (!rst_v[i] && !pre_v[i] && edge_v[i]) begin
                s_nxt.q[i] = d_v[i];
            end
            if (rst_v[i] && pre_v[i]) begin
                s_nxt.pin_out[i] = ~d_v[i];
            end else begin
                s_nxt.pin_out[i] = ~s_nxt.q[i];
            end
        end
        s_nxt.pin_oe_n = ~en_v;
        s_nxt.clk_prev = ck_v;
    end

    // *****************************
    // state register, power-on state
    // *****************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r.in_s1    <= `RST_SYNC_LOW;
            s_r.in_s2    <= `RST_SYNC_LOW;
            s_r.io_s1    <= `RST_SYNC_LOW;
            s_r.io_s2    <= `RST_SYNC_LOW;
            s_r.pre_s1   <= `RST_PRELOAD_N;
            s_r.pre_s2   <= `RST_PRELOAD_N;
            s_r.oe_s1    <= `RST_OUT_EN_N;
            s_r.oe_s2    <= `RST_OUT_EN_N;
            s_r.q        <= `RST_Q;
            s_r.clk_prev <= `RST_CLK_PREV;
            s_r.pin_out  <= `RST_PIN_OUT;
            s_r.pin_oe_n <= `RST_PIN_OE_N;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign io_out         = s_r.pin_out;
    assign io_oe_n        = s_r.pin_oe_n;
    assign user_signature = SIGNATURE;

    // *****************************
    // assertions
    // *****************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    property p_polarity;
        ((d_v ^ pol_v) & any_v) == '0 && ((d_v ^ ~pol_v) & ~any_v) == '0;
    endproperty
    a_polarity: assert property (p_polarity) else $error("data level disagrees with polarity");

    property p_preload_load;
        !s_r.pre_s2 |=> ((s_r.q ^ ~$past(s_r.io_s2)) & ~$past(en_v)) == '0;
    endproperty
    a_preload_load: assert property (p_preload_load) else $error("preload did not load io level");

    property p_preload_keep;
        !s_r.pre_s2 |=> ((s_r.q ^ $past(s_r.q)) & $past(en_v)) == '0;
    endproperty
    a_preload_keep: assert property (p_preload_keep) else $error("enabled cell changed in preload");

    property p_reset_clear;
        s_r.pre_s2 |=> (s_r.q & $past(rst_v & ~pre_v)) == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset term did not clear");

    property p_preset_set;
        s_r.pre_s2 |=> (~s_r.q & $past(pre_v & ~rst_v)) == '0;
    endproperty
    a_preset_set: assert property (p_preset_set) else $error("preset term did not set");

    property p_capture;
        s_r.pre_s2 |=> ((s_r.q ^ $past(d_v)) & $past(edge_v & ~rst_v & ~pre_v)) == '0;
    endproperty
    a_capture: assert property (p_capture) else $error("clock edge missed data");

    property p_hold;
        s_r.pre_s2 |=> ((s_r.q ^ $past(s_r.q)) & $past(~edge_v & ~(rst_v ^ pre_v))) == '0;
    endproperty
    a_hold: assert property (p_hold) else $error("flip-flop changed without cause");

    property p_invert;
        1'b1 |=> ((s_r.pin_out ^ ~s_r.q) & ~$past(rst_v & pre_v)) == '0;
    endproperty
    a_invert: assert property (p_invert) else $error("pin not inverse of flip-flop");

    property p_bypass;
        1'b1 |=> ((s_r.pin_out ^ ~$past(d_v)) & $past(rst_v & pre_v)) == '0;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass pin not inverse of data");

    property p_out_enable;
        s_r.oe_s2 |=> s_r.pin_oe_n == '1;
    endproperty
    a_out_enable: assert property (p_out_enable) else $error("pin driven with enable pin high");

    property p_drive_enabled;
        1'b1 |=> s_r.pin_oe_n == ~$past(en_v);
    endproperty
    a_drive_enabled: assert property (p_drive_enabled) else $error("pin enable disagrees with terms");

    property p_enable_term;
        1'b1 |=> (~s_r.pin_oe_n & ~$past(oet_v)) == '0;
    endproperty
    a_enable_term: assert property (p_enable_term) else $error("pin driven without enable term");

    property p_bypass_hold;
        s_r.pre_s2 |=> ((s_r.q ^ $past(s_r.q)) & $past(rst_v & pre_v)) == '0;
    endproperty
    a_bypass_hold: assert property (p_bypass_hold) else $error("flip-flop changed in bypass");

    property p_preload_wins;
        !s_r.pre_s2 |=> ((s_r.q ^ ~$past(s_r.io_s2)) & $past(~en_v & rst_v)) == '0;
    endproperty
    a_preload_wins: assert property (p_preload_wins) else $error("reset term beat preload");

    property p_preload_no_clock;
        !s_r.pre_s2 |=> ((s_r.q ^ ~$past(s_r.io_s2)) & $past(~en_v & edge_v)) == '0;
    endproperty
    a_preload_no_clock: assert property (p_preload_no_clock) else $error("clock edge beat preload");

    property p_preload_pin;
        !s_r.pre_s2 |=> ((s_r.pin_out ^ $past(s_r.io_s2)) & $past(~en_v & ~(rst_v & pre_v))) == '0;
    endproperty
    a_preload_pin: assert property (p_preload_pin) else $error("preloaded pin not io level");

    property p_preload_enabled_pin;
        !s_r.pre_s2 |=> ((s_r.pin_out ^ ~$past(s_r.q)) & $past(en_v & ~(rst_v & pre_v))) == '0;
    endproperty
    a_preload_enabled_pin: assert property (p_preload_enabled_pin) else $error("enabled pin moved in preload");

    property p_reset_pin;
        s_r.pre_s2 |=> (~s_r.pin_out & $past(rst_v & ~pre_v)) == '0;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset cell pin not high");

    property p_preset_pin;
        s_r.pre_s2 |=> (s_r.pin_out & $past(pre_v & ~rst_v)) == '0;
    endproperty
    a_preset_pin: assert property (p_preset_pin) else $error("preset cell pin not low");

    property p_reset_over_edge;
        s_r.pre_s2 |=> (s_r.q & $past(edge_v & rst_v & ~pre_v)) == '0;
    endproperty
    a_reset_over_edge: assert property (p_reset_over_edge) else $error("clock beat reset term");

    property p_preset_over_edge;
        s_r.pre_s2 |=> (~s_r.q & $past(edge_v & pre_v & ~rst_v)) == '0;
    endproperty
    a_preset_over_edge: assert property (p_preset_over_edge) else $error("clock beat preset term");

    property p_capture_active;
        s_r.pre_s2 |=> ((s_r.q ^ $past(pol_v)) & $past(edge_v & any_v & ~rst_v & ~pre_v)) == '0;
    endproperty
    a_capture_active: assert property (p_capture_active) else $error("active term captured wrong level");

    property p_capture_idle;
        s_r.pre_s2 |=> ((s_r.q ^ ~$past(pol_v)) & $past(edge_v & ~any_v & ~rst_v & ~pre_v)) == '0;
    endproperty
    a_capture_idle: assert property (p_capture_idle) else $error("idle terms captured wrong level");

    property p_clk_history;
        1'b1 |=> s_r.clk_prev == $past(ck_v);
    endproperty
    a_clk_history: assert property (p_clk_history) else $error("clock term history lost");

    // *****************************
    // synchroniser checks
    // *****************************
    property p_sync_in;
        1'b1 |=> s_r.in_s2 == $past(s_r.in_s1);
    endproperty
    a_sync_in: assert property (p_sync_in) else $error("input second stage skipped");

    property p_sync_io;
        1'b1 |=> s_r.io_s2 == $past(s_r.io_s1);
    endproperty
    a_sync_io: assert property (p_sync_io) else $error("io second stage skipped");

    property p_sync_pre;
        1'b1 |=> s_r.pre_s2 == $past(s_r.pre_s1);
    endproperty
    a_sync_pre: assert property (p_sync_pre) else $error("preload second stage skipped");

    property p_sync_oe;
        1'b1 |=> s_r.oe_s2 == $past(s_r.oe_s1);
    endproperty
    a_sync_oe: assert property (p_sync_oe) else $error("enable pin second stage skipped");

    c_preload: cover property (!s_r.pre_s2 ##1 s_r.pre_s2);
    c_bypass: cover property ((rst_v & pre_v) != '0);
    c_capture: cover property ((edge_v & ~rst_v & ~pre_v) != '0 ##1 s_r.q != $past(s_r.q));
    c_drive: cover property (s_r.pin_oe_n != '1);
    c_preset: cover property (s_r.pre_s2 && (pre_v & ~rst_v) != '0);

endmodule

// File: tb/board_model.sv
`timescale 1ns/1ps
module board_model (
    input  wire pld_pkg::mc_vec_t  io_out,
    input  wire pld_pkg::mc_vec_t  io_oe_n,
    input  wire pld_pkg::mc_vec_t  drv,
    output pld_pkg::mc_vec_t       io_in
);
    import pld_pkg::*;
    // ****************************
    // pin resolution
    // ****************************
    // board drives only the pins the cell has released
    always_comb begin
        io_in = (io_out & ~io_oe_n) | (drv & io_oe_n);
    end
endmodule

// File: tb/async_register_macrocells_tb.sv
`timescale 1ns/1ps
module async_register_macrocells_tb;
    import pld_pkg::*;
    localparam logic [63:0] SIG = 64'h1234_5678_9abc_def0;  // arbitrary value
    logic          core_clk;
    logic          arst_n;
    logic          preload_n;
    logic          out_en_n;
    fuse_map_t     fuse_map;
    logic [9:0]    ded_in;
    mc_vec_t       io_in;
    mc_vec_t       io_out;
    mc_vec_t       io_oe_n;
    mc_vec_t       drv;
    mc_vec_t       q_m;
    mc_vec_t       dv;
    logic [63:0]   user_signature;
    logic [31:0]   seed = 32'h5c4823d2;
    int            fails = 0;
    int            n_compared = 0;
    logic          clk_prev;

    async_register_macrocells #(.SIGNATURE(SIG)) i_async_register_macrocells (
        .core_clk(core_clk), .arst_n(arst_n), .fuse_map(fuse_map), .ded_in(ded_in),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .preload_n(preload_n),
        .out_en_n(out_en_n), .user_signature(user_signature));
    board_model i_board_model (.io_out(io_out), .io_oe_n(io_oe_n), .drv(drv), .io_in(io_in));

    // ****************************
    // helpers
    // ****************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic chk_vec(input mc_vec_t got, input mc_vec_t exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_sig(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t signature got %h", $time, got);
        end
    endtask

    task automatic close_out();
        $display("fails %0d compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************
    // clock and watchdog
    // ****************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        fails++;
        close_out();
    end

    // ****************************
    // stimulus and model
    // ****************************
    initial begin
        logic [9:0] d;
        logic       pr;
        logic       en;
        arst_n = 1'b0;
        preload_n = 1'b1;
        out_en_n = 1'b1;
        ded_in = 10'h000;
        drv = 10'h000;
        q_m = 10'h000;
        clk_prev = 1'b0;
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            fuse_map[i] = '0;
            fuse_map[i].polarity = seed[0];
            fuse_map[i].term[0].true_sel = 30'h1 << (i % 6);
            // unused logic terms never active
            for (int k = 1; k < 4; k++) fuse_map[i].term[k] = {30'h1, 30'h1};
            fuse_map[i].term[4].true_sel = 30'h200;
            fuse_map[i].term[5].true_sel = 30'h080;
            fuse_map[i].term[6].true_sel = 30'h100;
            fuse_map[i].term[7].true_sel = 30'h040;
        end
        repeat (12) @(posedge core_clk);
        #2 arst_n = 1'b1;
        @(posedge core_clk);
        #2;
        chk_vec(io_out, 10'h3ff, "reset pins");
        chk_vec(io_oe_n, 10'h3ff, "reset oe");
        chk_sig(user_signature, SIG);
        for (int n = 0; n < 80; n++) begin
            seed = xs(seed);
            d = seed[9:0];
            pr = (seed[12:10] == 3'h0);
            // preload keeps enables steady and bypass off
            if (pr) begin
                d[9] = 1'b0;
                d[6] = ded_in[6];
            end
            @(posedge core_clk);
            #2;
            ded_in = d;
            preload_n = ~pr;
            drv = seed[25:16];
            if (!pr) out_en_n = seed[28];
            repeat (5) @(posedge core_clk);
            #2;
            for (int i = 0; i < 10; i++) begin
                en = d[6] & ~out_en_n;
                dv[i] = d[i % 6] ? fuse_map[i].polarity : ~fuse_map[i].polarity;
                if (pr) begin
                    if (!en) q_m[i] = ~drv[i];
                end else if (d[9] & ~d[7]) begin
                    q_m[i] = 1'b0;
                end else if (d[7] & ~d[9]) begin
                    q_m[i] = 1'b1;
                end else if (!d[9] && d[8] && !clk_prev) begin
                    q_m[i] = dv[i];
                end
            end
            clk_prev = d[8];
            chk_vec(io_out, (d[9] & d[7]) ? ~dv : ~q_m, "pins");
            chk_vec(io_oe_n, {10{~(d[6] & ~out_en_n)}}, "oe");
        end
        close_out();
    end
endmodule
